/* hw/indirect_data_pointer_unit.sv */
// Indirect data pointer unit: three pointer pairs, operand redirection and
// an Avalon-MM register slave for software access to the pointers.
// Assumes a data memory that answers reads in the cycle of its request and
// a core that issues one operand access per clock cycle that its request is high.
`timescale 1ns/1ps

module indirect_data_pointer_unit #(
   parameter int NUM_PTR = ptr_unit_pkg::PTR_COUNT
) (
   input wire logic clock_i,
   input wire logic rst_i,
   // Avalon-MM register slave
   input wire logic [ptr_unit_pkg::BUS_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [ptr_unit_pkg::BUS_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [ptr_unit_pkg::BUS_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Core operand port
   input wire logic core_req_i,
   input wire logic core_we_i,
   input wire logic [7:0] core_file_addr_i,
   input wire logic core_access_i,
   input wire logic [3:0] bank_select_register_i,
   input wire logic [7:0] core_wdata_i,
   output logic core_rvalid_o,
   output logic [7:0] core_rdata_o,
   // Data memory port
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [ptr_unit_pkg::ADDR_W-1:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i
);

   localparam logic [1:0] NO_HIT = 2'd3;

   initial begin
      if (NUM_PTR != 3) begin
         $error("indirect_data_pointer_unit: exactly three pointer pairs are mapped");
      end
   end

   // Index of the entry of a table matching an address, or NO_HIT
   function automatic logic [1:0] match_index(input logic [7:0] addr, input logic [2:0][7:0] table_v);
      logic [1:0] idx;
      idx = NO_HIT;
      for (int i = 0; i < 3; i++) begin
         if (addr == table_v[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // Same search over bus offsets
   function automatic logic [1:0] bus_index(input logic [4:0] addr, input logic [2:0][4:0] table_v);
      logic [1:0] idx;
      idx = NO_HIT;
      for (int i = 0; i < 3; i++) begin
         if (addr == table_v[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // Pointer storage
   logic [7:0] ptr_lo [3];
   logic [7:0] ptr_hi [3];
   logic [ptr_unit_pkg::ADDR_W-1:0] ptr_addr [3];
   logic [2:0] lo_we;
   logic [2:0] hi_we;
   logic [7:0] ptr_wdata;

   // Core request decode
   logic [3:0] direct_bank;
   logic in_sfr;
   logic [1:0] ind_idx;
   logic [1:0] plo_idx;
   logic [1:0] phi_idx;
   logic is_ind;
   logic is_plo;
   logic is_phi;
   logic core_ptr_wr;
   logic [ptr_unit_pkg::ADDR_W-1:0] direct_addr;
   logic [ptr_unit_pkg::ADDR_W-1:0] sel_ptr_addr;
   logic [ptr_unit_pkg::ADDR_W-1:0] target_addr;
   logic [7:0] local_rdata;

   // Pipeline
   logic mem_req_q;
   logic mem_we_q;
   logic [ptr_unit_pkg::ADDR_W-1:0] mem_addr_q;
   logic [7:0] mem_wdata_q;
   logic s1_read_q;
   logic s1_local_q;
   logic [7:0] s1_local_data_q;
   logic core_rvalid_q;
   logic [7:0] core_rdata_q;
   logic [ptr_unit_pkg::ADDR_W-1:0] last_target_q;
   logic last_ind_q;
   logic last_wr_q;

   // Bus slave
   ptr_unit_pkg::bus_state_e bus_state_q;
   logic bus_req;
   logic bus_wr_fire;
   logic [1:0] bus_lo_idx;
   logic [1:0] bus_hi_idx;
   logic [ptr_unit_pkg::BUS_W-1:0] bus_rdata_d;
   logic [ptr_unit_pkg::BUS_W-1:0] bus_rdata_q;

   for (genvar n = 0; n < 3; n++) begin : g_ptr
      pointer_pair_reg #(
         .HI_BITS(ptr_unit_pkg::HI_USED)
      ) u_pair (
         .clock_i(clock_i),
         .rst_i(rst_i),
         .lo_we_i(lo_we[n]),
         .hi_we_i(hi_we[n]),
         .wdata_i(ptr_wdata),
         .lo_o(ptr_lo[n]),
         .hi_o(ptr_hi[n]),
         .addr_o(ptr_addr[n])
      );
      // Core writes win; the bus is held off in that cycle so nothing is lost
      assign lo_we[n] = (core_ptr_wr && is_plo && plo_idx == 2'(n))
                        || (bus_wr_fire && bus_lo_idx == 2'(n));
      assign hi_we[n] = (core_ptr_wr && is_phi && phi_idx == 2'(n))
                        || (bus_wr_fire && bus_hi_idx == 2'(n));
   end

   assign ptr_wdata = core_ptr_wr ? core_wdata_i : avs_writedata_i[7:0];

   // Direct addressing through bank select or the access split
   always_comb begin
      if (core_access_i) begin
         direct_bank = (core_file_addr_i >= ptr_unit_pkg::ACCESS_SPLIT)
                       ? ptr_unit_pkg::SFR_BANK : ptr_unit_pkg::ACCESS_LOW_BANK;
      end else begin
         direct_bank = bank_select_register_i;
      end
   end

   assign direct_addr = {direct_bank, core_file_addr_i};
   assign in_sfr = direct_bank == ptr_unit_pkg::SFR_BANK;
   assign ind_idx = match_index(core_file_addr_i, ptr_unit_pkg::IND_ADDR);
   assign plo_idx = match_index(core_file_addr_i, ptr_unit_pkg::PTR_LO_ADDR);
   assign phi_idx = match_index(core_file_addr_i, ptr_unit_pkg::PTR_HI_ADDR);
   assign is_ind = in_sfr && ind_idx != NO_HIT;
   assign is_plo = in_sfr && plo_idx != NO_HIT;
   assign is_phi = in_sfr && phi_idx != NO_HIT;
   assign core_ptr_wr = core_req_i && core_we_i && (is_plo || is_phi);

   // Redirection: the pointer alone forms the target, bank plays no part
   assign sel_ptr_addr = is_ind ? ptr_addr[ind_idx] : '0;
   assign target_addr = is_ind ? sel_ptr_addr : direct_addr;

   always_comb begin
      local_rdata = 8'h00;
      if (is_plo) begin
         local_rdata = ptr_lo[plo_idx];
      end else if (is_phi) begin
         local_rdata = ptr_hi[phi_idx];
      end
   end

   // Stage one: memory request, except for pointer bytes kept here
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= '0;
         mem_wdata_q <= 8'h00;
      end else begin
         mem_req_q <= core_req_i && !(is_plo || is_phi);
         mem_we_q <= core_req_i && core_we_i && !(is_plo || is_phi);
         if (core_req_i) begin
            mem_addr_q <= target_addr;
            mem_wdata_q <= core_wdata_i;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s1_read_q <= 1'b0;
         s1_local_q <= 1'b0;
         s1_local_data_q <= 8'h00;
      end else begin
         s1_read_q <= core_req_i && !core_we_i;
         s1_local_q <= is_plo || is_phi;
         s1_local_data_q <= local_rdata;
      end
   end

   // Stage two: read data back to the core
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         core_rvalid_q <= 1'b0;
         core_rdata_q <= 8'h00;
      end else begin
         core_rvalid_q <= s1_read_q;
         if (s1_read_q) begin
            core_rdata_q <= s1_local_q ? s1_local_data_q : mem_rdata_i;
         end
      end
   end

   // Last memory target, visible to software
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         last_target_q <= '0;
         last_ind_q <= 1'b0;
         last_wr_q <= 1'b0;
      end else if (core_req_i && !(is_plo || is_phi)) begin
         last_target_q <= target_addr;
         last_ind_q <= is_ind;
         last_wr_q <= core_we_i;
      end
   end

   assign mem_req_o = mem_req_q;
   assign mem_we_o = mem_we_q;
   assign mem_addr_o = mem_addr_q;
   assign mem_wdata_o = mem_wdata_q;
   assign core_rvalid_o = core_rvalid_q;
   assign core_rdata_o = core_rdata_q;

   // Avalon slave: one wait cycle, then the answer; held longer if the core
   // is writing a pointer at that moment
   assign bus_req = avs_read_i || avs_write_i;
   assign bus_lo_idx = bus_index(avs_address_i, ptr_unit_pkg::REG_PTR_LO);
   assign bus_hi_idx = bus_index(avs_address_i, ptr_unit_pkg::REG_PTR_HI);
   assign bus_wr_fire = avs_write_i && avs_byteenable_i[0] && !core_ptr_wr
                        && bus_state_q == ptr_unit_pkg::BUS_ACK;

   always_comb begin
      bus_rdata_d = '0;
      if (bus_lo_idx != NO_HIT) begin
         bus_rdata_d[7:0] = ptr_lo[bus_lo_idx];
      end else if (bus_hi_idx != NO_HIT) begin
         bus_rdata_d[7:0] = ptr_hi[bus_hi_idx];
      end else if (avs_address_i == ptr_unit_pkg::REG_TARGET) begin
         bus_rdata_d[ptr_unit_pkg::ADDR_W-1:0] = last_target_q;
         bus_rdata_d[ptr_unit_pkg::TGT_IND_BIT] = last_ind_q;
         bus_rdata_d[ptr_unit_pkg::TGT_WR_BIT] = last_wr_q;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         bus_state_q <= ptr_unit_pkg::BUS_IDLE;
      end else begin
         case (bus_state_q)
            ptr_unit_pkg::BUS_IDLE: begin
               if (bus_req) begin
                  bus_state_q <= ptr_unit_pkg::BUS_ACK;
               end
            end
            ptr_unit_pkg::BUS_ACK: begin
               if (!core_ptr_wr) begin
                  bus_state_q <= ptr_unit_pkg::BUS_IDLE;
               end
            end
            default: begin
               bus_state_q <= ptr_unit_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // Read data captured on entry to the answer cycle and refreshed while held
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         bus_rdata_q <= '0;
      end else if (avs_read_i) begin
         bus_rdata_q <= bus_rdata_d;
      end
   end

   always_comb begin
      case (bus_state_q)
         ptr_unit_pkg::BUS_IDLE: avs_waitrequest_o = bus_req;
         ptr_unit_pkg::BUS_ACK: avs_waitrequest_o = core_ptr_wr;
         default: avs_waitrequest_o = 1'b1;
      endcase
   end

   assign avs_readdata_o = bus_rdata_q;

   chk_ind_target: assert property (@(posedge clock_i) disable iff (rst_i)
      (core_req_i && is_ind) |=> (mem_req_o && mem_addr_o == $past(ptr_addr[ind_idx])))
      else $error("indirect access did not go to its pointer address");

   chk_pair_order: assert property (@(posedge clock_i) disable iff (rst_i)
      (core_req_i && is_ind && ind_idx == 2'd1)
      |=> mem_addr_o == {$past(ptr_hi[1][3:0]), $past(ptr_lo[1])})
      else $error("pointer bytes joined in the wrong order");

   chk_bank_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
      (core_req_i && is_ind && !core_access_i && bank_select_register_i == ptr_unit_pkg::SFR_BANK
       && ptr_addr[ind_idx][11:8] != ptr_unit_pkg::SFR_BANK)
      |=> mem_addr_o[11:8] != ptr_unit_pkg::SFR_BANK)
      else $error("bank select leaked into an indirect target");

   chk_no_storage: assert property (@(posedge clock_i) disable iff (rst_i)
      (core_req_i && is_ind && !core_we_i)
      |-> ##2 (core_rvalid_o && core_rdata_o == $past(mem_rdata_i)))
      else $error("indirect read was not served by data memory");

   chk_ind_write: assert property (@(posedge clock_i) disable iff (rst_i)
      (core_req_i && core_we_i && is_ind)
      |=> (mem_we_o && mem_wdata_o == $past(core_wdata_i)) ##1 !core_rvalid_o)
      else $error("indirect write did not reach memory");

   chk_linear_reach: assert property (@(posedge clock_i) disable iff (rst_i)
      (core_req_i && !is_ind && !is_plo && !is_phi)
      |=> mem_addr_o == {$past(direct_bank), $past(core_file_addr_i)})
      else $error("direct access lost its bank");

   chk_bus_wait: assert property (@(posedge clock_i) disable iff (rst_i)
      (bus_req && avs_waitrequest_o && bus_state_q == ptr_unit_pkg::BUS_IDLE && !core_ptr_wr)
      ##1 !core_ptr_wr |-> !avs_waitrequest_o)
      else $error("bus slave held waitrequest too long");

   chk_bus_ptr_write: assert property (@(posedge clock_i) disable iff (rst_i)
      (bus_wr_fire && bus_lo_idx == 2'd2) |=> ptr_lo[2] == $past(avs_writedata_i[7:0]))
      else $error("bus write to pointer low byte was lost");

   chk_hi_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      ptr_hi[0][7:4] == 4'h0 && ptr_hi[1][7:4] == 4'h0 && ptr_hi[2][7:4] == 4'h0)
      else $error("unused high nibble reads nonzero");

   chk_ptr_width: assert property (@(posedge clock_i) disable iff (rst_i)
      (core_req_i && core_we_i && is_phi && phi_idx == 2'd0)
      |=> ptr_addr[0][11:8] == $past(core_wdata_i[3:0]))
      else $error("pointer does not carry twelve bits");

endmodule

/* pkg/ptr_unit_pkg.sv */
// Shared constants for the indirect data pointer unit: bus offsets, core-side
// operand addresses, widths, reset values and the bus slave state encoding.
// Assumes a 12-bit linear data memory and an 8-bit core file address.
package ptr_unit_pkg;

   localparam int PTR_COUNT = 3;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int HI_USED = 4;
   localparam int BUS_W = 32;
   localparam int BUS_ADDR_W = 5;

   // Pointer bytes come out of reset cleared
   localparam logic [7:0] PTR_RESET = 8'h00;

   // Avalon byte offsets, one aligned word per register
   localparam logic [2:0][4:0] REG_PTR_LO = {5'h10, 5'h08, 5'h00};
   localparam logic [2:0][4:0] REG_PTR_HI = {5'h14, 5'h0c, 5'h04};
   localparam logic [4:0] REG_TARGET = 5'h18;

   // Field positions inside the target status word
   localparam int TGT_IND_BIT = 12;
   localparam int TGT_WR_BIT = 13;

   // Core-side bank numbers, the access split and file addresses inside the special-function bank
   localparam logic [3:0] SFR_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [2:0][7:0] IND_ADDR = {8'hc2, 8'hc1, 8'hc0};
   localparam logic [2:0][7:0] PTR_LO_ADDR = {8'hc8, 8'hc6, 8'hc4};
   localparam logic [2:0][7:0] PTR_HI_ADDR = {8'hc9, 8'hc7, 8'hc5};

   // Core request to read data: memory request edge, then return edge
   localparam int READ_LATENCY = 2;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_e;

endpackage

/* hw/pointer_pair_reg.sv */
// One pointer pair: a low byte and a high byte whose upper nibble is not kept.
// Assumes the parent resolves write priority and hands over one data byte.
`timescale 1ns/1ps

module pointer_pair_reg #(
   parameter int HI_BITS = ptr_unit_pkg::HI_USED
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic lo_we_i,
   input wire logic hi_we_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] lo_o,
   output logic [7:0] hi_o,
   output logic [ptr_unit_pkg::ADDR_W-1:0] addr_o
);

   logic [7:0] lo_q;
   logic [HI_BITS-1:0] hi_q;

   initial begin
      if (HI_BITS + 8 != ptr_unit_pkg::ADDR_W) begin
         $error("pointer_pair_reg: high part width must complete the address");
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         lo_q <= ptr_unit_pkg::PTR_RESET;
      end else if (lo_we_i) begin
         lo_q <= wdata_i;
      end
   end

   // Upper nibble is simply not stored, so writes there vanish
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         hi_q <= ptr_unit_pkg::PTR_RESET[HI_BITS-1:0];
      end else if (hi_we_i) begin
         hi_q <= wdata_i[HI_BITS-1:0];
      end
   end

   assign lo_o = lo_q;
   assign hi_o = {{(8 - HI_BITS){1'b0}}, hi_q};
   assign addr_o = {hi_q, lo_q};

   chk_hi_masked: assert property (@(posedge clock_i) disable iff (rst_i)
      hi_we_i |=> hi_o == {4'h0, $past(wdata_i[3:0])})
      else $error("high byte did not keep only its low nibble");

endmodule

/* bench/data_mem_model.sv */
// Behavioural data memory facing the pointer unit's memory port.
// Assumes reads answer combinationally while a read request is high.
`timescale 1ns/1ps

module data_mem_model (
   input wire logic clock_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [ptr_unit_pkg::ADDR_W-1:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] mem [4096];
   logic [7:0] last_q;

   initial begin
      last_q = 8'h5a;
      for (int a = 0; a < 4096; a++) begin
         mem[a] = 8'(a) ^ {4'(a >> 8), 4'(a >> 8)};
      end
   end

   // One flat space, no banking in the way
   always @(posedge clock_i) begin
      if (mem_req_i && mem_we_i) begin
         mem[mem_addr_i] <= mem_wdata_i;
      end
   end

   always @(posedge clock_i) begin
      last_q <= mem_rdata_o;
   end

   // Outside a read the bus shows the inverse of last cycle's value, so the previous cycle's data cannot pass a check
   assign mem_rdata_o = (mem_req_i && !mem_we_i) ? mem[mem_addr_i] : ~last_q;
endmodule

/* bench/indirect_data_pointer_unit_tb.sv */
// Self-checking bench for the indirect data pointer unit.
// Assumes the data memory model answers reads in the cycle of the request.
`timescale 1ns/1ps

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module indirect_data_pointer_unit_tb;
   logic clock_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [4:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, ea, rnd;
   logic [3:0] avs_byteenable_i, bank_select_register_i;
   logic core_req_i, core_we_i, core_access_i, core_rvalid_o, mem_req_o, mem_we_o;
   logic [7:0] core_file_addr_i, core_wdata_i, core_rdata_o, mem_wdata_o, mem_rdata_i, er, bd;
   logic [11:0] mem_addr_o;
   logic [20:0] em;
   logic [31:0] aq[$];
   logic [20:0] mq[$];
   logic [7:0] rq[$];
   logic [7:0] shadow [4096];
   logic [7:0] plo [3];
   logic [7:0] phi [3];
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;

   indirect_data_pointer_unit i_indirect_data_pointer_unit (.clock_i(clock_i), .rst_i(rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .core_req_i(core_req_i), .core_we_i(core_we_i), .core_file_addr_i(core_file_addr_i),
      .core_access_i(core_access_i), .bank_select_register_i(bank_select_register_i),
      .core_wdata_i(core_wdata_i), .core_rvalid_o(core_rvalid_o), .core_rdata_o(core_rdata_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));

   data_mem_model i_data_mem_model (.clock_i(clock_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   task automatic final_report();
      if (aq.size() + mq.size() + rq.size() != 0) n_fail++;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Sized for a run of a few hundred cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         final_report();
      end
   end

   // Monitor: every result takes the oldest note of its kind
   always @(posedge clock_i) begin
      if (!rst_i && avs_read_i && !avs_waitrequest_o) begin
         ea = aq.size() ? aq.pop_front() : 'x;
         `CHK(avs_readdata_o, ea)
      end
      if (!rst_i && mem_req_o) begin
         em = mq.size() ? mq.pop_front() : 'x;
         `CHK(mem_we_o, em[20])
         `CHK(mem_addr_o, em[19:8])
         if (em[20]) `CHK(mem_wdata_o, em[7:0])
      end
      if (!rst_i && core_rvalid_o) begin
         er = rq.size() ? rq.pop_front() : 'x;
         `CHK(core_rdata_o, er)
      end
   end

   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                      input logic [31:0] exp);
      @(posedge clock_i);
      rnd = $urandom();
      avs_address_i <= a;
      avs_writedata_i <= {rnd[31:8], d};
      avs_byteenable_i <= be;
      if (wr) begin
         avs_write_i <= 1'b1;
         for (int k = 0; k < 3; k++) begin
            if (be[0] && a == ptr_unit_pkg::REG_PTR_LO[k]) plo[k] = d;
            if (be[0] && a == ptr_unit_pkg::REG_PTR_HI[k]) phi[k] = {4'h0, d[3:0]};
         end
      end else begin
         avs_read_i <= 1'b1;
         aq.push_back(exp);
      end
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic check_ptrs();
      for (int k = 0; k < 3; k++) begin
         bus(1'b0, ptr_unit_pkg::REG_PTR_LO[k], 8'h00, 4'hf, {24'h0000_00, plo[k]});
         bus(1'b0, ptr_unit_pkg::REG_PTR_HI[k], 8'h00, 4'hf, {24'h0000_00, phi[k]});
      end
   endtask

   // Called right after an edge; back-to-back calls keep the request high
   task automatic core_op(input logic we, input logic [7:0] fa, input logic acc, input logic [3:0] bank_select_register,
                          input logic [7:0] wd);
      logic [3:0] bank;
      logic [11:0] tgt;
      logic local_hit;
      bank = acc ? ((fa >= ptr_unit_pkg::ACCESS_SPLIT) ? ptr_unit_pkg::SFR_BANK : 4'h0) : bank_select_register;
      tgt = {bank, fa};
      local_hit = 1'b0;
      core_req_i <= 1'b1;
      core_we_i <= we;
      core_file_addr_i <= fa;
      core_access_i <= acc;
      bank_select_register_i <= bank_select_register;
      core_wdata_i <= wd;
      for (int k = 0; k < 3; k++) begin
         if (bank == ptr_unit_pkg::SFR_BANK && fa == ptr_unit_pkg::IND_ADDR[k]) begin
            tgt = {phi[k][3:0], plo[k]};
         end
         // Pointer bytes are served locally and never reach memory
         if (bank == ptr_unit_pkg::SFR_BANK && fa == ptr_unit_pkg::PTR_LO_ADDR[k]) begin
            local_hit = 1'b1;
            if (we) plo[k] = wd;
            else rq.push_back(plo[k]);
         end
         if (bank == ptr_unit_pkg::SFR_BANK && fa == ptr_unit_pkg::PTR_HI_ADDR[k]) begin
            local_hit = 1'b1;
            if (we) phi[k] = {4'h0, wd[3:0]};
            else rq.push_back(phi[k]);
         end
      end
      if (!local_hit) begin
         mq.push_back({we, tgt, wd});
         if (we) shadow[tgt] = wd;
         else rq.push_back(shadow[tgt]);
      end
      @(posedge clock_i);
   endtask

   task automatic core_idle();
      core_req_i <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic indirect_pair(input int k);
      logic m;
      m = 1'($urandom());
      // Bank select is random whenever the access bit supplies the bank
      core_op(1'b1, ptr_unit_pkg::IND_ADDR[k], m, m ? 4'($urandom()) : 4'hf, 8'($urandom()));
      core_op(1'b0, ptr_unit_pkg::IND_ADDR[k], !m, m ? 4'hf : 4'($urandom()), 8'($urandom()));
   endtask

   initial begin
      {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
      {core_req_i, core_we_i, core_file_addr_i, core_access_i, bank_select_register_i, core_wdata_i} = '0;
      rst_i = 1'b1;
      for (int a = 0; a < 4096; a++) shadow[a] = 8'(a) ^ {4'(a >> 8), 4'(a >> 8)};
      for (int k = 0; k < 3; k++) {plo[k], phi[k]} = 16'h0000;
      void'($urandom(5));
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      check_ptrs();
      bus(1'b0, ptr_unit_pkg::REG_TARGET, 8'h00, 4'hf, 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, ptr_unit_pkg::REG_PTR_LO[k], 8'($urandom()), 4'hf, 32'h0000_0000);
         bus(1'b1, ptr_unit_pkg::REG_PTR_HI[k], 8'($urandom()) | 8'hf0, 4'hf, 32'h0000_0000);
      end
      check_ptrs();
      // Lane 0 disabled and an unmapped word must both leave the pointers alone
      bus(1'b1, ptr_unit_pkg::REG_PTR_LO[0], 8'h00, 4'he, 32'h0000_0000);
      bus(1'b1, 5'h1c, 8'h77, 4'hf, 32'h0000_0000);
      bus(1'b0, 5'h1c, 8'h00, 4'hf, 32'h0000_0000);
      check_ptrs();
      @(posedge clock_i);
      repeat (12) begin
         n = $urandom_range(2, 0);
         indirect_pair(n);
      end
      // Random operands: mostly direct, banked by the access bit or bank select
      repeat (16) begin
         core_op(1'($urandom()), 8'($urandom()), 1'($urandom()), 4'($urandom()), 8'($urandom()));
      end
      // Core rewrites pointer 1 to the top address, writes and reads pointer 0's high byte, then uses pointer 1
      core_op(1'b1, ptr_unit_pkg::PTR_LO_ADDR[1], 1'b0, 4'hf, 8'hff);
      core_op(1'b1, ptr_unit_pkg::PTR_HI_ADDR[1], 1'b1, 4'h3, 8'hff);
      core_op(1'b1, ptr_unit_pkg::PTR_HI_ADDR[0], 1'b1, 4'h0, 8'($urandom()));
      core_op(1'b0, ptr_unit_pkg::PTR_HI_ADDR[0], 1'b0, 4'hf, 8'h00);
      indirect_pair(1);
      core_idle();
      bus(1'b1, ptr_unit_pkg::REG_PTR_LO[2], 8'h00, 4'hf, 32'h0000_0000);
      bus(1'b1, ptr_unit_pkg::REG_PTR_HI[2], 8'h00, 4'hf, 32'h0000_0000);
      // Core pointer write in the bus answer cycle lands first; the stalled bus write lands after it
      bd = 8'($urandom());
      fork
         bus(1'b1, ptr_unit_pkg::REG_PTR_LO[0], bd, 4'hf, 32'h0000_0000);
         begin
            core_idle();
            core_idle();
            core_op(1'b1, ptr_unit_pkg::PTR_LO_ADDR[0], 1'b1, 4'h0, 8'($urandom()));
            core_idle();
         end
      join
      plo[0] = bd;
      @(posedge clock_i);
      core_op(1'b1, ptr_unit_pkg::IND_ADDR[2], 1'b1, 4'h5, 8'h3c);
      core_idle();
      check_ptrs();
      bus(1'b0, ptr_unit_pkg::REG_TARGET, 8'h00, 4'hf, 32'h0000_3000);
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 3; k++) {plo[k], phi[k]} = 16'h0000;
      check_ptrs();
      @(posedge clock_i);
      indirect_pair(0);
      core_idle();
      repeat (4) @(posedge clock_i);
      final_report();
   end
endmodule
